/* shared/csa_pkg.sv */
// shared constants and carriers of the completion stream adapter
// assumes one user clock; the 256-bit beat is the only width with straddling
package csa_pkg;
  localparam int DATA_W = 256;
  localparam int KEEP_W = DATA_W / 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int RC_SB_W = 75;
  localparam int CC_SB_W = 33;
  // completion sideband fields, and the dword offset of the upper half beat
  localparam int SB_BYTE_EN_LSB = 0;
  localparam int SB_FIRST_START = 32;
  localparam int SB_SECOND_START = 33;
  localparam int SB_FIRST_END_LSB = 34;
  localparam int SB_SECOND_END_LSB = 38;
  localparam int SB_DISCONTINUE = 41;
  localparam int HALF_DW = 4;
  // descriptor bits within a beat, and the completer sideband discontinue bit
  localparam int DESC_POISON = 46;
  localparam int DESC_ECRC = 95;
  localparam int DESC_BC_LSB = 16;
  localparam int DESC_BC_W = 13;
  localparam int CC_SB_DISCONTINUE = 0;
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RX_FRAMES = 4'h4;
  localparam logic [3:0] ADDR_TX_FRAMES = 4'h8;
  localparam int CTRL_STRADDLE = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic              start;
    logic              frame_end;
    logic [2:0]        end_dword;
    logic              poison;
    logic              err;
  } csa_rx_beat_type;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [KEEP_W-1:0]  keep;
    logic [CC_SB_W-1:0] sideband;
    logic               last;
  } csa_cc_beat_type;

  typedef enum logic {RX_PASS, RX_SECOND} csa_rx_state_type;
endpackage

/* core/csa_keep_map.sv */
// byte strobes to dword keep, and last dword byte enables from byte count
// assumes strobes are dword-contiguous from bit 0 upward
`timescale 1ns/1ps
module csa_keep_map (
  input  wire logic [csa_pkg::STRB_W-1:0]    strb,
  input  wire logic [csa_pkg::DESC_BC_W-1:0] byte_count,
  output logic [csa_pkg::KEEP_W-1:0] keep,
  output logic [3:0]                 last_be
);
  // one keep bit for each group of four strobes
  genvar gi;
  generate
    for (gi = 0; gi < csa_pkg::KEEP_W; gi++) begin : g_dw
      assign keep[gi] = |strb[4*gi +: 4];
    end
  endgenerate

  // last dword enables from the low byte count bits; none without a dword
  always_comb begin
    case (byte_count[1:0])
      2'h1: last_be = 4'h1;
      2'h2: last_be = 4'h3;
      2'h3: last_be = 4'h7;
      default: last_be = 4'hf;
    endcase
    if (keep == '0) begin
      last_be = 4'h0;
    end
  end
endmodule

/* core/csa_adapter.sv */
// completion stream adapter: completion stream to legacy receive frames,
// legacy transmit beats to completer completions, wishbone control
// assumes both streams and the bus run on mclk; no clock crossing inside
//
// Operation
// - split two straddled completions into two frames
// - start flags from sideband 32, 33 if straddling
// - end flags from 37:34, 41:38 if straddling
// - poison from data 46 on start beats, from data 174 for an upper packet
// - last dword enables from keep and count
// - four byte strobes make one keep bit
// - ecrc 95, poison 46, abort to discontinue
`timescale 1ns/1ps
module csa_adapter (
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  // wishbone slave
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [3:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic [31:0]                         wb_dat_o,
  output logic                                wb_ack_o,
  // completion stream from the core
  input  wire logic [csa_pkg::DATA_W-1:0]     completion_data,
  input  wire logic [csa_pkg::KEEP_W-1:0]     completion_dword_keep,
  input  wire logic [csa_pkg::RC_SB_W-1:0]    completion_sideband,
  input  wire logic                           completion_valid,
  output logic                                completion_ready,
  // legacy receive frames to user logic
  output csa_pkg::csa_rx_beat_type            legacy_rx,
  output logic                                legacy_rx_valid,
  input  wire logic                           legacy_rx_ready,
  // legacy transmit beats from user logic
  input  wire logic [csa_pkg::DATA_W-1:0]     legacy_tx_data,
  input  wire logic [csa_pkg::STRB_W-1:0]     legacy_tx_strb,
  input  wire logic                           legacy_tx_last,
  input  wire logic                           legacy_tx_ecrc,
  input  wire logic                           legacy_tx_poison,
  input  wire logic                           legacy_tx_abort,
  input  wire logic                           legacy_tx_valid,
  output logic                                legacy_tx_ready,
  // completer completion stream to the core
  output csa_pkg::csa_cc_beat_type            completer,
  output logic [3:0]                          completer_last_be,
  output logic                                completer_valid,
  input  wire logic                           completer_ready
);
  logic                       straddle_reg, straddle_next;
  logic [csa_pkg::CNT_W-1:0]  rx_cnt_reg, rx_cnt_next;
  logic [csa_pkg::CNT_W-1:0]  tx_cnt_reg, tx_cnt_next;
  logic [31:0]                dat_reg, dat_next;
  logic                       ack_reg, ack_next;
  csa_pkg::csa_rx_state_type  rx_state_reg, rx_state_next;
  csa_pkg::csa_rx_beat_type   rx_out_reg, rx_out_next;
  logic                       rx_v_reg, rx_v_next;
  logic [csa_pkg::DATA_W-1:0] hold_data_reg, hold_data_next;
  logic [csa_pkg::KEEP_W-1:0] hold_keep_reg, hold_keep_next;
  logic [csa_pkg::RC_SB_W-1:0] hold_sb_reg, hold_sb_next;
  csa_pkg::csa_cc_beat_type   cc_reg, cc_next;
  logic [3:0]                 last_be_reg, last_be_next;
  logic                       cc_v_reg, cc_v_next;
  logic                       tx_first_reg, tx_first_next;
  logic [csa_pkg::DESC_BC_W-1:0] bc_reg, bc_next;
  logic [csa_pkg::DESC_BC_W-1:0] bc_src;
  logic [csa_pkg::KEEP_W-1:0] map_keep;
  logic [3:0]                 map_last_be;
  logic                       rx_adv, tx_adv, split;

  // build one legacy frame beat; kind 0 whole beat, 1 lower packet, 2 upper packet
  function automatic csa_pkg::csa_rx_beat_type frame(
    input logic [csa_pkg::DATA_W-1:0]  d,
    input logic [csa_pkg::KEEP_W-1:0]  k,
    input logic [csa_pkg::RC_SB_W-1:0] sb,
    input logic                        strad,
    input logic [1:0]                  kind
  );
    csa_pkg::csa_rx_beat_type b;
    logic s0, s1, e0v, e1v;
    logic [2:0] e0p, e1p;
    logic [csa_pkg::KEEP_W-1:0] dwm;
    b = '0;
    s0 = sb[csa_pkg::SB_FIRST_START];
    s1 = strad & sb[csa_pkg::SB_SECOND_START];
    e0v = sb[csa_pkg::SB_FIRST_END_LSB];
    e0p = sb[csa_pkg::SB_FIRST_END_LSB+1 +: 3];
    e1v = strad & sb[csa_pkg::SB_SECOND_END_LSB];
    e1p = sb[csa_pkg::SB_SECOND_END_LSB+1 +: 3];
    dwm = k;
    b.data = d;
    b.err = sb[csa_pkg::SB_DISCONTINUE];
    case (kind)
      2'h1: begin
        // lower packet ends inside the beat
        for (int i = 0; i < csa_pkg::KEEP_W; i++) begin
          if (i > int'(e0p)) begin
            dwm[i] = 1'b0;
          end
        end
        b.start = s0;
        b.frame_end = 1'b1;
        b.end_dword = e0p;
        b.poison = s0 & d[csa_pkg::DESC_POISON];
      end
      2'h2: begin
        // upper packet starts at the half-beat dword
        for (int i = 0; i < csa_pkg::HALF_DW; i++) begin
          dwm[i] = 1'b0;
        end
        b.start = 1'b1;
        b.frame_end = e1v;
        b.end_dword = e1p;
        b.poison = d[csa_pkg::HALF_DW*32 + csa_pkg::DESC_POISON];
      end
      default: begin
        b.start = s0 | s1;
        b.frame_end = e0v | e1v;
        b.end_dword = e0v ? e0p : e1p;
        if (s0) begin
          b.poison = d[csa_pkg::DESC_POISON];
        end else if (s1) begin
          b.poison = d[csa_pkg::HALF_DW*32 + csa_pkg::DESC_POISON];
        end
      end
    endcase
    for (int i = 0; i < csa_pkg::KEEP_W; i++) begin
      b.strb[4*i +: 4] = sb[csa_pkg::SB_BYTE_EN_LSB + 4*i +: 4] & {4{dwm[i]}};
    end
    return b;
  endfunction

  // wishbone: ack one cycle after the strobe, dropped the cycle after
  always_comb begin
    straddle_next = straddle_reg;
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next = 32'h0000_0000;
    if (ack_next) begin
      case (wb_adr_i)
        csa_pkg::ADDR_CTRL: begin
          dat_next[csa_pkg::CTRL_STRADDLE] = straddle_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            straddle_next = wb_dat_i[csa_pkg::CTRL_STRADDLE];
          end
        end
        csa_pkg::ADDR_RX_FRAMES: dat_next[csa_pkg::CNT_W-1:0] = rx_cnt_reg;
        csa_pkg::ADDR_TX_FRAMES: dat_next[csa_pkg::CNT_W-1:0] = tx_cnt_reg;
        default: dat_next = 32'h0000_0000; // unmapped reads zero, writes dropped
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      straddle_reg <= csa_pkg::CTRL_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      straddle_reg <= straddle_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // receive: a straddled beat is held and replayed as a second frame
  assign rx_adv = ~rx_v_reg | legacy_rx_ready;
  assign completion_ready = (rx_state_reg == csa_pkg::RX_PASS) & rx_adv;
  assign split = straddle_reg & completion_sideband[csa_pkg::SB_SECOND_START]
               & completion_sideband[csa_pkg::SB_FIRST_END_LSB];

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_out_next = rx_out_reg;
    rx_v_next = rx_v_reg & ~legacy_rx_ready;
    hold_data_next = hold_data_reg;
    hold_keep_next = hold_keep_reg;
    hold_sb_next = hold_sb_reg;
    rx_cnt_next = rx_cnt_reg;
    if (rx_v_reg && legacy_rx_ready && rx_out_reg.frame_end) begin
      rx_cnt_next = rx_cnt_reg + 1'b1;
    end
    case (rx_state_reg)
      csa_pkg::RX_PASS: begin
        if (completion_valid && rx_adv) begin
          rx_v_next = 1'b1;
          if (split) begin
            rx_out_next = frame(completion_data, completion_dword_keep,
                                completion_sideband, 1'b1, 2'h1);
            hold_data_next = completion_data;
            hold_keep_next = completion_dword_keep;
            hold_sb_next = completion_sideband;
            rx_state_next = csa_pkg::RX_SECOND;
          end else begin
            rx_out_next = frame(completion_data, completion_dword_keep,
                                completion_sideband, straddle_reg, 2'h0);
          end
        end
      end
      csa_pkg::RX_SECOND: begin
        if (rx_adv) begin
          rx_v_next = 1'b1;
          rx_out_next = frame(hold_data_reg, hold_keep_reg, hold_sb_reg,
                              1'b1, 2'h2);
          rx_state_next = csa_pkg::RX_PASS;
        end
      end
      default: rx_state_next = csa_pkg::RX_PASS;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= csa_pkg::RX_PASS;
      rx_out_reg <= '0;
      rx_v_reg <= 1'b0;
      hold_data_reg <= '0;
      hold_keep_reg <= '0;
      hold_sb_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_out_reg <= rx_out_next;
      rx_v_reg <= rx_v_next;
      hold_data_reg <= hold_data_next;
      hold_keep_reg <= hold_keep_next;
      hold_sb_reg <= hold_sb_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  assign legacy_rx = rx_out_reg;
  assign legacy_rx_valid = rx_v_reg;

  // byte count comes from the descriptor beat and is kept for the packet
  assign bc_src = tx_first_reg ? legacy_tx_data[csa_pkg::DESC_BC_LSB +: csa_pkg::DESC_BC_W]
                               : bc_reg;

  csa_keep_map u_keep_map (
    .strb       (legacy_tx_strb),
    .byte_count (bc_src),
    .keep       (map_keep),
    .last_be    (map_last_be)
  );

  // transmit: one register stage; ready falls only while the core stalls
  assign tx_adv = ~cc_v_reg | completer_ready;
  assign legacy_tx_ready = tx_adv;

  always_comb begin
    cc_next = cc_reg;
    cc_v_next = cc_v_reg & ~completer_ready;
    last_be_next = last_be_reg;
    tx_first_next = tx_first_reg;
    bc_next = bc_reg;
    tx_cnt_next = tx_cnt_reg;
    if (cc_v_reg && completer_ready && cc_reg.last) begin
      tx_cnt_next = tx_cnt_reg + 1'b1;
    end
    if (tx_adv && legacy_tx_valid) begin
      cc_v_next = 1'b1;
      cc_next.data = legacy_tx_data;
      if (tx_first_reg) begin
        cc_next.data[csa_pkg::DESC_ECRC] = legacy_tx_ecrc;
        cc_next.data[csa_pkg::DESC_POISON] = legacy_tx_poison;
      end
      cc_next.keep = map_keep;
      cc_next.sideband = '0;
      cc_next.sideband[csa_pkg::CC_SB_DISCONTINUE] = legacy_tx_abort;
      cc_next.last = legacy_tx_last;
      last_be_next = legacy_tx_last ? map_last_be : 4'hf;
      bc_next = bc_src;
      tx_first_next = legacy_tx_last;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cc_reg <= '0;
      cc_v_reg <= 1'b0;
      last_be_reg <= 4'h0;
      tx_first_reg <= 1'b1;
      bc_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      cc_reg <= cc_next;
      cc_v_reg <= cc_v_next;
      last_be_reg <= last_be_next;
      tx_first_reg <= tx_first_next;
      bc_reg <= bc_next;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  assign completer = cc_reg;
  assign completer_valid = cc_v_reg;
  assign completer_last_be = last_be_reg;
endmodule

/* tb/csa_adapter_checker.sv */
// assertions on the adapter's stream handshakes, beat mapping and bus ack
// assumes one clock mclk and the async active-low nrst of the adapter
`timescale 1ns/1ps
module csa_adapter_checker (
  input wire logic                       mclk,
  input wire logic                       nrst,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  input wire logic                       completion_valid,
  input wire logic                       completion_ready,
  input wire csa_pkg::csa_rx_beat_type   legacy_rx,
  input wire logic                       legacy_rx_valid,
  input wire logic                       legacy_rx_ready,
  input wire logic [csa_pkg::STRB_W-1:0] legacy_tx_strb,
  input wire logic                       legacy_tx_last,
  input wire logic                       legacy_tx_abort,
  input wire logic                       legacy_tx_valid,
  input wire logic                       legacy_tx_ready,
  input wire csa_pkg::csa_cc_beat_type   completer,
  input wire logic                       completer_valid,
  input wire logic                       completer_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a transmit beat is taken, a bus request is open
  sequence s_tx_take; legacy_tx_valid && legacy_tx_ready; endsequence
  sequence s_wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_tx_ready; legacy_tx_ready == (!completer_valid || completer_ready); endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready wrong");
  property p_tx_take; s_tx_take |=> completer_valid; endproperty
  a_tx_take: assert property (p_tx_take) else $error("tx beat lost");
  property p_cc_hold; completer_valid && !completer_ready |=> completer_valid && $stable(completer);
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("completer beat not held");
  property p_keep; s_tx_take |=> completer.keep[0] == $past(|legacy_tx_strb[3:0])
    && completer.keep[3] == $past(|legacy_tx_strb[15:12]); endproperty
  a_keep: assert property (p_keep) else $error("keep not from strobes");
  property p_abort; s_tx_take |=> completer.sideband[0] == $past(legacy_tx_abort)
    && completer.last == $past(legacy_tx_last); endproperty
  a_abort: assert property (p_abort) else $error("abort or last lost");
  property p_rx_take; completion_valid && completion_ready |=> legacy_rx_valid; endproperty
  a_rx_take: assert property (p_rx_take) else $error("rx beat lost");
  property p_rc_ready; completion_ready |-> !legacy_rx_valid || legacy_rx_ready; endproperty
  a_rc_ready: assert property (p_rc_ready) else $error("ready while stalled");
  property p_rx_hold; legacy_rx_valid && !legacy_rx_ready |=> legacy_rx_valid && $stable(legacy_rx);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx frame not held");
  property p_wb; s_wb_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_wb: assert property (p_wb) else $error("bus ack not a single pulse");
endmodule
bind csa_adapter csa_adapter_checker chk (.*);

/* tb/csa_core_model.sv */
// model of the protocol core side: sends completion beats, sinks completions
// assumes mclk shared with the adapter; stall slows the completer sink
`timescale 1ns/1ps
module csa_core_model (
  input  wire logic                        mclk,
  output logic [csa_pkg::DATA_W-1:0]       completion_data,
  output logic [csa_pkg::KEEP_W-1:0]       completion_dword_keep,
  output logic [csa_pkg::RC_SB_W-1:0]      completion_sideband,
  output logic                             completion_valid,
  input  wire logic                        completion_ready,
  output logic                             completer_ready
);
  logic stall;
  // slow answers only when the bench asks for them
  assign completer_ready = !stall;
  initial begin
    stall = 1'b0;
    completion_valid = 1'b0;
    completion_data = '0;
    completion_sideband = '0;
    completion_dword_keep = 8'hff;
  end
  // one beat, possibly two straddled packets; held until ready is sampled
  task automatic send(input logic [csa_pkg::DATA_W-1:0] d,
                      input logic [csa_pkg::RC_SB_W-1:0] s);
    @(posedge mclk);
    completion_data <= d;
    completion_sideband <= s;
    completion_valid <= 1'b1;
    do @(posedge mclk); while (completion_ready !== 1'b1);
    completion_valid <= 1'b0;
    // released bus shows no stale beat
    completion_data <= ~d;
    completion_sideband <= ~s;
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench of the completion stream adapter
// assumes csa_pkg compiled first; checker is bound, core model beside uut
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  logic                         mclk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]                   wb_adr_i, wb_sel_i, completer_last_be;
  logic [31:0]                  wb_dat_i, wb_dat_o, rd, legacy_tx_strb;
  logic [csa_pkg::DATA_W-1:0]   completion_data, legacy_tx_data;
  logic [csa_pkg::KEEP_W-1:0]   completion_dword_keep;
  logic [csa_pkg::RC_SB_W-1:0]  completion_sideband;
  logic                         completion_valid, completion_ready, legacy_rx_valid;
  logic                         legacy_rx_ready, legacy_tx_last, legacy_tx_ecrc;
  logic                         legacy_tx_poison, legacy_tx_abort, legacy_tx_valid;
  logic                         legacy_tx_ready, completer_valid, completer_ready;
  csa_pkg::csa_rx_beat_type     legacy_rx;
  csa_pkg::csa_cc_beat_type     completer;
  int                           fail_count, total_checks, cycles;
  csa_adapter uut (.*);
  csa_core_model core (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // hang guard, far above the few dozen cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // classic single cycle, released only after ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, d};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic tx(input logic [31:0] s, input logic l, e, p, a, input logic [12:0] bc);
    logic [csa_pkg::DATA_W-1:0] d;
    d = '0;
    d[28:16] = bc;
    @(posedge mclk);
    legacy_tx_data <= d;
    {legacy_tx_strb, legacy_tx_last, legacy_tx_ecrc, legacy_tx_poison} <= {s, l, e, p};
    {legacy_tx_abort, legacy_tx_valid} <= {a, 1'b1};
    do @(posedge mclk); while (legacy_tx_ready !== 1'b1);
    legacy_tx_valid <= 1'b0;
    #1;
  endtask
  function automatic logic [74:0] sb(input logic s0, s1, input logic [3:0] e0, e1);
    sb = '0;
    sb[31:0] = 32'hffffffff;
    sb[33:32] = {s1, s0};
    sb[41:34] = {e1, e0};
  endfunction
  task automatic t_regs;
    wb(1'b1, csa_pkg::ADDR_CTRL, 32'h1);
    wb(1'b0, csa_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    // a control write without lane 0 must not touch the straddle bit
    wb_sel_i <= 4'he;
    wb(1'b1, csa_pkg::ADDR_CTRL, 32'h0);
    wb_sel_i <= 4'hf;
    wb(1'b0, csa_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl lane", 32'h1, rd)
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("done regs");
  endtask
  // two packets in one beat, output stalled on the first
  task automatic t_rx_split;
    logic [csa_pkg::DATA_W-1:0] d;
    d = '0;
    d[174] = 1'b1;
    legacy_rx_ready <= 1'b0;
    core.send(d, sb(1'b1, 1'b1, 4'h7, 4'h5));
    #1 `CHK("f1 end", 5'h1b, {legacy_rx_valid, legacy_rx.frame_end, legacy_rx.end_dword})
    `CHK("f1 poison", 2'b10, {legacy_rx.start, legacy_rx.poison})
    `CHK("f1 strb", 32'h0000ffff, legacy_rx.strb)
    repeat (2) @(posedge mclk);
    #1 `CHK("f1 held", 4'hb, {legacy_rx_valid, legacy_rx.end_dword})
    legacy_rx_ready <= 1'b1;
    @(posedge mclk);
    #1 `CHK("f2", 5'h1a, {legacy_rx_valid, legacy_rx.start, legacy_rx.end_dword})
    `CHK("f2 poison", 2'b10, {legacy_rx.poison, legacy_rx.err})
    `CHK("f2 strb", 32'hffff0000, legacy_rx.strb)
    @(posedge mclk);
    #1 `CHK("f2 once", 1'b0, legacy_rx_valid)
    $display("done rx split");
  endtask
  task automatic t_rx_nostrad;
    logic [csa_pkg::DATA_W-1:0] d;
    d = '0;
    d[46] = 1'b1;
    wb(1'b1, csa_pkg::ADDR_CTRL, 32'h0);
    core.send(d, sb(1'b1, 1'b1, 4'h7, 4'h5));
    #1 `CHK("one frame", 3'h3, legacy_rx.end_dword)
    `CHK("poison", 1'b1, legacy_rx.poison)
    @(posedge mclk);
    #1 `CHK("no second", 1'b0, legacy_rx_valid)
    core.send(d, sb(1'b0, 1'b0, 4'hf, 4'h0));
    #1 `CHK("no sof poison", 2'b00, {legacy_rx.start, legacy_rx.poison})
    $display("done rx no straddle");
  endtask
  task automatic t_tx;
    logic [3:0] k [4];
    k = '{4'h1, 4'h3, 4'h7, 4'hf};
    tx(32'h0000ffff, 1'b0, 1'b1, 1'b1, 1'b0, 13'h5);
    `CHK("ecrc", 2'b11, {completer.data[95], completer.data[46]})
    `CHK("bc", 13'h5, completer.data[28:16])
    for (int i = 0; i < 4; i++) begin
      tx(32'hffff >> (12 - 4 * i), 1'b0, 1'b1, 1'b0, 1'b0, 13'h0);
      `CHK("keep", {4'h0, k[i]}, completer.keep)
      `CHK("mid", 5'h0f, {completer.data[95], completer_last_be})
    end
    // let the last middle beat drain before the sink stalls
    @(posedge mclk);
    core.stall <= 1'b1;
    tx(32'h0000000f, 1'b1, 1'b0, 1'b0, 1'b1, 13'h0);
    repeat (2) @(posedge mclk);
    #1 `CHK("held", 2'b11, {completer_valid, completer.last})
    `CHK("abort", 1'b1, completer.sideband[0])
    `CHK("last be", 4'h1, completer_last_be)
    core.stall = 1'b0;
    @(posedge mclk);
    #1 `CHK("drained", 1'b0, completer_valid)
    $display("done tx");
  endtask
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    legacy_rx_ready = 1'b1;
    legacy_tx_data = '0;
    {legacy_tx_strb, legacy_tx_last, legacy_tx_ecrc} = '0;
    {legacy_tx_poison, legacy_tx_abort, legacy_tx_valid} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_rx_split();
    t_rx_nostrad();
    t_tx();
    wb(1'b0, csa_pkg::ADDR_RX_FRAMES, 32'h0);
    `CHK("rx frames", 32'h4, rd)
    wb(1'b0, csa_pkg::ADDR_TX_FRAMES, 32'h0);
    `CHK("tx frames", 32'h1, rd)
    give_verdict();
  end
endmodule
